// ===== rtl/bxs_pkg.sv
/*
 * Package for the bridge excitation sequencer: mode encodings, the pin and status
 * carrier structs, and the timing counts.
 * Assumes a single 20 MHz master clock, which stands in for the converter's master clock pin.
 */
// Summary of operation
// - source bit 0 internal, 1 external excitation
// - internal dc: drive A low, B high
// - external mode makes drive A an input
// - external A held high means dc
// - internal ac divides master clock by select
// - internal ac phases A and B never overlap
// - one idle master cycle between phases
// - external mode echoes phased clock on B
// - blank sampling 64 cycles after each edge
// - one filter word per 81920 cycles
// - restart begins on first edge after release
package bxs_pkg;
    localparam int unsigned BXS_SETTLE_CYCLES = 64;
    localparam int unsigned BXS_WORD_CYCLES = 81920;
    localparam int unsigned BXS_SETTLE_PERIODS = 6;
    localparam logic BXS_SRC_INTERNAL = 1'h0;
    localparam logic BXS_SRC_EXTERNAL = 1'h1;
    localparam logic [1:0] BXS_SEL_DC = 2'h0;

    // excitation phase state, Gray along the a -> gap -> b -> gap loop
    typedef enum logic [1:0] {
        BXS_PH_A = 2'h0,
        BXS_GAP_AB = 2'h1,
        BXS_PH_B = 2'h3,
        BXS_GAP_BA = 2'h2
    } bxs_phase_t;

    typedef struct packed {
        logic drive_a_out;
        logic drive_a_oe_b;
        logic drive_b_out;
    } bxs_pins_t;

    typedef struct packed {
        logic sample_enable;
        logic word_strobe;
        logic settled;
    } bxs_status_t;
endpackage

// ===== rtl/bxs_sequencer.sv
/*
 * Bridge excitation sequencer: internal two-phase or dc drive, external excitation
 * follow-through, sample blanking after each drive edge and the filter word pacing.
 * Assumes all inputs are synchronous to CLK and the external excitation is
 * derived from the same master clock.
 */
`timescale 1ns/1ps
module bxs_sequencer
    import bxs_pkg::*;
#(
    parameter int unsigned DIV_SEL1 = 2048,
    parameter int unsigned DIV_SEL2 = 4096,
    parameter int unsigned DIV_SEL3 = 8192,
    parameter int unsigned WORD_CYCLES = BXS_WORD_CYCLES,
    parameter int unsigned SETTLE_CYCLES = BXS_SETTLE_CYCLES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // configuration
    input wire logic EXCITATION_SOURCE,
    input wire logic EXCITATION_FREQ_SEL_HI,
    input wire logic EXCITATION_FREQ_SEL_LO,
    input wire logic FILTER_RESTART_BIT,
    // bridge drive pins
    input wire logic BRIDGE_DRIVE_A_IN,
    output bxs_pins_t BRIDGE_PINS,
    // sampling and filter pacing
    output bxs_status_t STATUS
);
    localparam int CW = 17;

    wire logic external_mode = (EXCITATION_SOURCE == BXS_SRC_EXTERNAL);
    wire logic [1:0] freq_sel = {EXCITATION_FREQ_SEL_HI, EXCITATION_FREQ_SEL_LO};
    wire logic internal_dc = !external_mode && (freq_sel == BXS_SEL_DC);
    // the phase generator is parked whenever it is not making ac excitation
    wire logic ac_idle = external_mode || internal_dc;
    // half period in master cycles, one of which is the gap
    wire logic [CW-1:0] half_period = (freq_sel == 2'h1) ? CW'(DIV_SEL1 / 2) :
                                      (freq_sel == 2'h2) ? CW'(DIV_SEL2 / 2) :
                                      CW'(DIV_SEL3 / 2);

    bxs_phase_t phase_q, phase_d;
    logic [CW-1:0] div_q;
    logic ext_a_q;
    logic a_q, b_q;
    logic [6:0] blank_q;
    logic [CW-1:0] word_q;
    logic [2:0] periods_q;
    logic strobe_q;

    wire logic div_done = (div_q == '0);
    wire logic in_gap = (phase_q == BXS_GAP_AB) || (phase_q == BXS_GAP_BA);

    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            BXS_PH_A: if (div_done) phase_d = BXS_GAP_AB;
            BXS_GAP_AB: phase_d = BXS_PH_B;
            BXS_PH_B: if (div_done) phase_d = BXS_GAP_BA;
            BXS_GAP_BA: phase_d = BXS_PH_A;
        endcase
    end

    // external: A is the excitation input, level held high reads as dc
    wire logic a_d = external_mode ? 1'h0 :
                     internal_dc ? 1'h0 : (phase_q == BXS_PH_A);
    wire logic b_d = external_mode ? ext_a_q :
                     internal_dc ? 1'h1 : (phase_q == BXS_PH_B);
    wire logic edge_seen = external_mode ? (b_d != b_q) : ((a_d != a_q) || (b_d != b_q));

    always_ff @(posedge CLK) begin
        if (!RST_B || internal_dc || external_mode) begin
            phase_q <= BXS_PH_A;
            div_q <= half_period - CW'(2);
        end else begin
            phase_q <= phase_d;
            div_q <= (in_gap || div_done) ? half_period - CW'(2) : div_q - CW'(1);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ext_a_q <= 1'h0;
            a_q <= 1'h0;
            b_q <= 1'h1;
            blank_q <= 7'h0;
        end else begin
            ext_a_q <= BRIDGE_DRIVE_A_IN;
            a_q <= a_d;
            b_q <= b_d;
            // restart the blanking window on every drive edge
            blank_q <= edge_seen ? 7'(SETTLE_CYCLES) :
                       (blank_q != 7'h0) ? blank_q - 7'h1 : 7'h0;
        end
    end

    // held in restart; counting begins on the first edge after release
    always_ff @(posedge CLK) begin
        if (!RST_B || FILTER_RESTART_BIT) begin
            word_q <= '0;
            strobe_q <= 1'h0;
            periods_q <= 3'h0;
        end else begin
            strobe_q <= (word_q == CW'(WORD_CYCLES - 1));
            word_q <= (word_q == CW'(WORD_CYCLES - 1)) ? '0 : word_q + CW'(1);
            if (word_q == CW'(WORD_CYCLES - 1) && periods_q != 3'(BXS_SETTLE_PERIODS)) begin
                periods_q <= periods_q + 3'h1;
            end
        end
    end

    assign BRIDGE_PINS.drive_a_out = a_q;
    assign BRIDGE_PINS.drive_a_oe_b = external_mode;
    assign BRIDGE_PINS.drive_b_out = b_q;
    assign STATUS.sample_enable = (blank_q == 7'h0);
    assign STATUS.word_strobe = strobe_q;
    assign STATUS.settled = (periods_q == 3'(BXS_SETTLE_PERIODS));

    // checker-only counters: long spans are measured here so that the
    // properties below need no long repetitions
    logic [CW-1:0] a_len_q;
    logic [CW-1:0] b_len_q;
    logic [CW-1:0] half_a_q;
    logic [CW-1:0] half_b_q;
    logic b_paced_q;
    logic [CW-1:0] word_gap_q;
    logic [6:0] low_len_q;

    // each phase length is taken from the selector latched when that phase
    // was loaded, so a selector change mid-phase does not trip the check
    always_ff @(posedge CLK) begin
        if (!RST_B || ac_idle) begin
            a_len_q <= '0;
            b_len_q <= '0;
            half_a_q <= half_period;
            half_b_q <= half_period;
            b_paced_q <= 1'h0;
        end else begin
            a_len_q <= a_q ? a_len_q + CW'(1) : '0;
            b_len_q <= b_q ? b_len_q + CW'(1) : '0;
            if (phase_q == BXS_GAP_BA) begin
                half_a_q <= half_period;
            end
            if (phase_q == BXS_GAP_AB) begin
                half_b_q <= half_period;
                b_paced_q <= 1'h1;
            end
        end
    end

    // cycles since the last strobe, or since the filter was let go
    always_ff @(posedge CLK) begin
        if (!RST_B || FILTER_RESTART_BIT) begin
            word_gap_q <= '0;
        end else begin
            word_gap_q <= strobe_q ? CW'(1) : word_gap_q + CW'(1);
        end
    end

    // blanked cycles since the most recent drive edge
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            low_len_q <= 7'h0;
        end else begin
            low_len_q <= (edge_seen || STATUS.sample_enable) ? 7'h0 : low_len_q + 7'h1;
        end
    end

    // drive phase shape
    nonoverlap_a: assert property (@(posedge CLK) disable iff (!RST_B)
        !(a_q && b_q && !external_mode)) else $error("drive phases overlap");
    dc_levels_a: assert property (@(posedge CLK) disable iff (!RST_B)
        internal_dc [*2] |-> !a_q && b_q) else $error("dc levels wrong");
    gap_width_a: assert property (@(posedge CLK) disable iff (!RST_B || ac_idle)
        $fell(a_q) |-> !b_q ##1 b_q) else $error("gap not one cycle");
    gap_ba_a: assert property (@(posedge CLK) disable iff (!RST_B || ac_idle)
        $fell(b_q) && b_paced_q |-> !a_q ##1 a_q) else $error("gap b to a wrong");
    phase_a_len_a: assert property (@(posedge CLK) disable iff (!RST_B || ac_idle)
        $fell(a_q) |-> a_len_q == half_a_q - CW'(1)) else $error("drive a length wrong");
    phase_b_len_a: assert property (@(posedge CLK) disable iff (!RST_B || ac_idle)
        $fell(b_q) && b_paced_q |-> b_len_q == half_b_q - CW'(1)) else $error("drive b length");

    // sample blanking
    blank_edge_a: assert property (@(posedge CLK) disable iff (!RST_B)
        $changed(b_q) |-> !STATUS.sample_enable) else $error("sampled at edge");
    blank_a_edge_a: assert property (@(posedge CLK) disable iff (!RST_B)
        $changed(a_q) && !external_mode |-> !STATUS.sample_enable) else $error("sampled at a");
    blank_len_a: assert property (@(posedge CLK) disable iff (!RST_B)
        $rose(STATUS.sample_enable) |-> low_len_q == 7'(SETTLE_CYCLES)) else $error("blank length");

    // external excitation
    ext_echo_a: assert property (@(posedge CLK) disable iff (!RST_B)
        external_mode [*3] |-> b_q == $past(BRIDGE_DRIVE_A_IN, 2)) else $error("echo wrong");
    ext_a_input_a: assert property (@(posedge CLK) disable iff (!RST_B)
        external_mode |-> BRIDGE_PINS.drive_a_oe_b) else $error("a driven in ext");
    ext_a_quiet_a: assert property (@(posedge CLK) disable iff (!RST_B)
        external_mode [*2] |-> !BRIDGE_PINS.drive_a_out) else $error("a not quiet in ext");
    ext_dc_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (external_mode && BRIDGE_DRIVE_A_IN) [*3] |-> b_q) else $error("ext dc not static");
    int_drive_a: assert property (@(posedge CLK) disable iff (!RST_B)
        !external_mode |-> !BRIDGE_PINS.drive_a_oe_b) else $error("a released in int");

    // filter word pacing
    restart_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
        FILTER_RESTART_BIT |=> word_q == '0 && !strobe_q) else $error("restart ignored");
    strobe_space_a: assert property (@(posedge CLK) disable iff (!RST_B || FILTER_RESTART_BIT)
        strobe_q |=> !strobe_q) else $error("strobe too long");
    word_space_a: assert property (@(posedge CLK) disable iff (!RST_B || FILTER_RESTART_BIT)
        strobe_q |-> word_gap_q == CW'(WORD_CYCLES)) else $error("word spacing wrong");
    word_phase_a: assert property (@(posedge CLK) disable iff (!RST_B)
        strobe_q |-> word_q == '0) else $error("strobe off count wrap");
    settled_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
        STATUS.settled && !FILTER_RESTART_BIT |=> STATUS.settled) else $error("settled lost");
endmodule

// ===== testbench/bxs_bridge_model.sv
/* bridge driver and external excitation counter model, feeding drive A.
   assumes CLK is the master clock; it changes its output at the falling edge. */
`timescale 1ns/1ps
module bxs_bridge_model (
    // master clock and control
    input wire logic CLK,
    input wire logic HOLD_HIGH,
    input wire logic [3:0] HALF,
    // excitation toward drive A
    output logic EXC
);
    logic [3:0] cnt_q = 4'h0;
    initial EXC = 1'b1;
    // equal halves from the master clock keep the duty at one half, no jitter
    always @(negedge CLK) begin
        cnt_q <= (cnt_q + 4'h1 >= HALF) ? 4'h0 : cnt_q + 4'h1;
        if (HOLD_HIGH) EXC <= 1'b1;
        else if (cnt_q + 4'h1 >= HALF) EXC <= ~EXC;
    end
endmodule

// ===== testbench/testbench.sv
/* self-checking bench for the excitation sequencer.
   assumes short divide ratios and a 64-cycle word to keep the run brief. */
`timescale 1ns/1ps
module testbench;
    import bxs_pkg::*;
    logic CLK = 0, RST_B = 0, src = 0, hi = 0, lo = 0, rf = 1, hold = 1, a_in, p1, p2;
    logic [3:0] half = 4'h3;
    bxs_pins_t pins;
    bxs_status_t st;
    wire [3:0] obs = {st.word_strobe, st.sample_enable, pins.drive_b_out, pins.drive_a_out};
    int n_mismatch = 0, n_checks = 0, seed = 32'h7470, i, c, s;
    bxs_bridge_model bm_u (.CLK(CLK), .HOLD_HIGH(hold), .HALF(half), .EXC(a_in));
    bxs_sequencer #(.DIV_SEL1(8), .DIV_SEL2(12), .DIV_SEL3(16), .WORD_CYCLES(64)) dut_u (
        .CLK(CLK), .RST_B(RST_B), .EXCITATION_SOURCE(src), .EXCITATION_FREQ_SEL_HI(hi),
        .EXCITATION_FREQ_SEL_LO(lo), .FILTER_RESTART_BIT(rf), .BRIDGE_DRIVE_A_IN(a_in),
        .BRIDGE_PINS(pins), .STATUS(st));
    initial forever #25 CLK = ~CLK;
    function automatic int div_of(int sel);
        return sel == 1 ? 8 : sel == 2 ? 12 : 16;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic step();
        p2 = p1;
        p1 = a_in;
        @(negedge CLK);
        #1;
        if (!src) chk(pins.drive_a_out & pins.drive_b_out, 0);
    endtask
    // counts samples while obs[k] holds v; bounded so a stuck output ends the run
    task automatic len(input int k, input logic v, output int n);
        n = 0;
        while (obs[k] === v && n < 200) begin
            n++;
            step();
        end
        if (n >= 200) begin
            n_mismatch++;
            results();
        end
    endtask
    initial begin
        repeat (5) step();
        RST_B = 1;
        step();
        chk(obs, 4'h6);
        chk(pins.drive_a_oe_b, 0);
        for (i = 0; i < 4; i++) begin
            s = i < 3 ? i + 1 : 1 + $unsigned($random(seed)) % 3;
            {hi, lo} = s[1:0];
            repeat (2) begin len(0, 1, c); len(0, 0, c); end
            len(0, 1, c);
            chk(c, div_of(s) / 2 - 1);
            len(1, 0, c);
            chk(c, 1);
            len(1, 1, c);
            chk(c, div_of(s) / 2 - 1);
            chk(obs[2], 0);
        end
        $display("test internal done");
        {hi, lo} = 2'h0;
        src = 1;
        hold = 0;
        half = 4'h2 + $unsigned($random(seed)) % 4;
        repeat (8) step();
        repeat (40) begin
            step();
            chk(pins.drive_b_out, p2);
            chk({pins.drive_a_out, pins.drive_a_oe_b}, 2'h1);
        end
        for (c = 0; a_in && c < 20; c++) step();
        chk(a_in, 0);
        hold = 1;
        len(1, 1, c);
        len(1, 0, c);
        len(2, 0, c);
        chk(c, BXS_SETTLE_CYCLES);
        repeat (20) step();
        chk(obs[1], 1);
        $display("test external done");
        rf = 0;
        step();
        len(3, 0, c);
        chk(c, 63);
        for (i = 0; i < 6; i++) begin
            len(3, 1, c);
            chk(c, 1);
            if (i < 5) len(3, 0, c);
            if (i < 5) chk(c, 63);
        end
        chk(st.settled, 1);
        $display("test word done");
        results();
    end
endmodule
